// ===== src/fsq_map.svh
// constants for the flash command timing sequencer: command codes and timings
`ifndef FSQ_MAP_SVH
`define FSQ_MAP_SVH

// ==========================================================
// command words written to the flash command register
`define FSQ_CMD_READ_PAGE    8'h01
`define FSQ_CMD_PROG_PAGE    8'h02
`define FSQ_CMD_CHECK_PAGE   8'h04
`define FSQ_CMD_ERASE_PAGE   8'h05
`define FSQ_CMD_ERASE_ALL    8'h06
`define FSQ_CMD_READ_BYTE    8'h81
`define FSQ_CMD_PROG_BYTE    8'h82
`define FSQ_CMD_LEAVE_LOAD   8'h0f
`define FSQ_CMD_ENTER_LOAD   8'hf0

// ==========================================================
// readback values after a page check
`define FSQ_CHECK_PASS       8'h00
`define FSQ_CHECK_FAIL       8'h01

// ==========================================================
// timing: machine clock rate and operation durations
`define FSQ_CLK_MHZ          40
`define FSQ_T_READ_PAGE_CYC  22
`define FSQ_T_READ_BYTE_CYC  9
`define FSQ_T_PROG_PAGE_US   380
`define FSQ_T_PROG_BYTE_US   200
`define FSQ_T_ERASE_US       2000
`define FSQ_T_LOAD_PAGE_US   16500
`define FSQ_US_DIV_LAST      6'h27

`endif

// ===== src/fsq_pkg.sv
// types shared by the flash command timing sequencer
package fsq_pkg;

	// ======================================================
	// operations handed to the flash array
	typedef enum logic [2:0]
	{
		FSQ_OP_NONE,
		FSQ_OP_READ_PAGE,
		FSQ_OP_PROG_PAGE,
		FSQ_OP_CHECK_PAGE,
		FSQ_OP_ERASE_PAGE,
		FSQ_OP_ERASE_ALL,
		FSQ_OP_READ_BYTE,
		FSQ_OP_PROG_BYTE
	} fsq_op_t;

	// ======================================================
	// request to the array: start pulse, target array, operation
	typedef struct packed
	{
		logic    start;
		logic    prog_array;
		fsq_op_t op;
	} fsq_arr_req_t;

endpackage

// ===== src/fsq_sequencer.sv
// flash command timing sequencer: decodes command words, times them, stalls the core
`include "fsq_map.svh"

// What this block does
// - data-array page read and page check each hold the core exactly 22 cycles
// - data page program 380 us, byte program 200 us, byte read 9 cycles
// - every page erase and whole-array erase, either array, lasts 2 ms
// - program-array 256-byte page program from expanded RAM lasts 16.5 ms
// - load mode: 64-byte page erase, 56 kB array erase, byte program 200 us
// - an operation starts on the command write itself, no start strobe
// - the core is held idle while any operation runs
// - the instruction after the command write waits for the operation to end
// - interrupts stay pending while the core is held, taken afterwards
// - counters and timers keep running; only the core is stalled
// - after a page check the command register reads zero on match, else nonzero
// - F0 selects the program array for later commands, 0F the data array
// - writing 06 erases the whole currently selected array
module fsq_sequencer
#(
	parameter logic [14:0] T_PROG_PAGE_US = 15'(`FSQ_T_PROG_PAGE_US),
	parameter logic [14:0] T_PROG_BYTE_US = 15'(`FSQ_T_PROG_BYTE_US),
	parameter logic [14:0] T_ERASE_US     = 15'(`FSQ_T_ERASE_US),
	parameter logic [14:0] T_LOAD_PAGE_US = 15'(`FSQ_T_LOAD_PAGE_US)
)
(
	input  wire logic                 sys_clk,       // machine clock, 40 MHz
	input  wire logic                 rst,           // async reset, active high
	input  wire logic                 cmd_wr,        // core writes command register
	input  wire logic [7:0]           cmd_wdata,     // command word
	input  wire logic [31:0]          data_regs,     // flash data registers, byte 1 low
	input  wire logic [31:0]          arr_rd_data,   // word read from the array
	output logic [7:0]                cmd_rdata_q,   // command register readback
	output logic                      core_hold_q,   // stall core and defer interrupts
	output logic                      load_mode_q,   // program array selected
	output fsq_pkg::fsq_arr_req_t     arr_q,         // request to the array
	output logic [31:0]               rd_data_q,     // read result for data registers
	output logic                      rd_load_q,     // pulse: load rd_data_q
	output logic                      done_q         // pulse: operation finished
);
	import fsq_pkg::*;

	typedef enum logic [1:0] {FSQ_ST_IDLE, FSQ_ST_CYC, FSQ_ST_US} fsq_state_t;

	localparam int unsigned CYC_PROG_PAGE = 32'(T_PROG_PAGE_US) * `FSQ_CLK_MHZ;
	localparam int unsigned CYC_PROG_BYTE = 32'(T_PROG_BYTE_US) * `FSQ_CLK_MHZ;
	localparam int unsigned CYC_ERASE     = 32'(T_ERASE_US) * `FSQ_CLK_MHZ;
	localparam int unsigned CYC_LOAD_PAGE = 32'(T_LOAD_PAGE_US) * `FSQ_CLK_MHZ;

	fsq_state_t state_q;
	fsq_op_t    cur_op_q;
	fsq_op_t    new_op;
	logic [14:0] cnt_q;
	logic [5:0]  pre_q;
	logic        us_tick;
	logic        start;
	logic        done_w;
	logic [19:0] hold_len_q;

	// ======================================================
	// command decode; reads and checks do not exist for the program array
	function automatic fsq_op_t fsq_decode(input logic [7:0] cmd, input logic load);
		fsq_op_t op;
		op = FSQ_OP_NONE;
		case (cmd)
			`FSQ_CMD_READ_PAGE:  op = load ? FSQ_OP_NONE : FSQ_OP_READ_PAGE;
			`FSQ_CMD_PROG_PAGE:  op = FSQ_OP_PROG_PAGE;
			`FSQ_CMD_CHECK_PAGE: op = load ? FSQ_OP_NONE : FSQ_OP_CHECK_PAGE;
			`FSQ_CMD_ERASE_PAGE: op = FSQ_OP_ERASE_PAGE;
			`FSQ_CMD_ERASE_ALL:  op = FSQ_OP_ERASE_ALL;
			`FSQ_CMD_READ_BYTE:  op = load ? FSQ_OP_NONE : FSQ_OP_READ_BYTE;
			`FSQ_CMD_PROG_BYTE:  op = FSQ_OP_PROG_BYTE;
			default:             op = FSQ_OP_NONE;
		endcase
		return op;
	endfunction

	// ======================================================
	// duration minus one: machine cycles for reads and page checks, microseconds otherwise
	function automatic logic [14:0] fsq_dur(input fsq_op_t op, input logic load);
		logic [14:0] d;
		d = 15'h0001;
		case (op)
			FSQ_OP_READ_PAGE,
			FSQ_OP_CHECK_PAGE: d = 15'(`FSQ_T_READ_PAGE_CYC);
			FSQ_OP_READ_BYTE:  d = 15'(`FSQ_T_READ_BYTE_CYC);
			FSQ_OP_PROG_PAGE:  d = load ? T_LOAD_PAGE_US : T_PROG_PAGE_US;
			FSQ_OP_PROG_BYTE:  d = T_PROG_BYTE_US;
			FSQ_OP_ERASE_PAGE,
			FSQ_OP_ERASE_ALL:  d = T_ERASE_US;
			default:           d = 15'h0001;
		endcase
		return d - 15'h0001;
	endfunction

	function automatic logic fsq_is_cyc(input fsq_op_t op);
		return op == FSQ_OP_READ_PAGE || op == FSQ_OP_CHECK_PAGE || op == FSQ_OP_READ_BYTE;
	endfunction

	// ======================================================
	// start on the command write itself; writes while busy cannot arrive
	// because the core is stalled, so they are simply not looked at
	assign new_op  = fsq_decode(cmd_wdata, load_mode_q);
	assign start   = cmd_wr && state_q == FSQ_ST_IDLE && new_op != FSQ_OP_NONE;
	assign us_tick = pre_q == `FSQ_US_DIV_LAST;
	assign done_w  = (state_q == FSQ_ST_CYC && cnt_q == 15'h0000)
		|| (state_q == FSQ_ST_US && us_tick && cnt_q == 15'h0000);

	// ======================================================
	// microsecond prescaler, restarted per operation so durations are exact
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pre_q <= 6'h00;
		else if (start || us_tick || state_q != FSQ_ST_US)
			pre_q <= 6'h00;
		else
			pre_q <= pre_q + 6'h01;
	end

	// ======================================================
	// sequencer state and duration counter
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q  <= FSQ_ST_IDLE;
			cnt_q    <= 15'h0000;
			cur_op_q <= FSQ_OP_NONE;
		end
		else
		begin
			case (state_q)
				FSQ_ST_IDLE:
				begin
					if (start)
					begin
						state_q  <= fsq_is_cyc(new_op) ? FSQ_ST_CYC : FSQ_ST_US;
						cnt_q    <= fsq_dur(new_op, load_mode_q);
						cur_op_q <= new_op;
					end
				end
				FSQ_ST_CYC:
				begin
					if (done_w)
						state_q <= FSQ_ST_IDLE;
					else
						cnt_q <= cnt_q - 15'h0001;
				end
				FSQ_ST_US:
				begin
					if (done_w)
						state_q <= FSQ_ST_IDLE;
					else if (us_tick)
						cnt_q <= cnt_q - 15'h0001;
				end
				default:
					state_q <= FSQ_ST_IDLE;
			endcase
		end
	end

	// ======================================================
	// core stall; the core holds interrupts pending while this is high,
	// while timers stay on their own enables and are never gated here
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			core_hold_q <= 1'b0;
		else if (start)
			core_hold_q <= 1'b1;
		else if (done_w)
			core_hold_q <= 1'b0;
	end

	// ======================================================
	// array selection, toggled only by the two mode commands
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			load_mode_q <= 1'b0;
		else if (cmd_wr && state_q == FSQ_ST_IDLE && cmd_wdata == `FSQ_CMD_ENTER_LOAD)
			load_mode_q <= 1'b1;
		else if (cmd_wr && state_q == FSQ_ST_IDLE && cmd_wdata == `FSQ_CMD_LEAVE_LOAD)
			load_mode_q <= 1'b0;
	end

	// ======================================================
	// array request; page size follows the selected array
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			arr_q <= '{start: 1'b0, prog_array: 1'b0, op: FSQ_OP_NONE};
		else if (start)
			arr_q <= '{start: 1'b1, prog_array: load_mode_q, op: new_op};
		else
			arr_q.start <= 1'b0;
	end

	// ======================================================
	// completion, read capture and check result
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			done_q      <= 1'b0;
			rd_load_q   <= 1'b0;
			rd_data_q   <= 32'h0000_0000;
			cmd_rdata_q <= 8'h00;
		end
		else
		begin
			done_q    <= done_w;
			rd_load_q <= done_w && (cur_op_q == FSQ_OP_READ_PAGE || cur_op_q == FSQ_OP_READ_BYTE);
			if (done_w && (cur_op_q == FSQ_OP_READ_PAGE || cur_op_q == FSQ_OP_READ_BYTE))
				rd_data_q <= arr_rd_data;
			if (done_w && cur_op_q == FSQ_OP_CHECK_PAGE)
				cmd_rdata_q <= (arr_rd_data == data_regs) ? `FSQ_CHECK_PASS
					: `FSQ_CHECK_FAIL;
			else if (cmd_wr && state_q == FSQ_ST_IDLE)
				cmd_rdata_q <= cmd_wdata;
		end
	end

	// ======================================================
	// stall length seen by the checks below
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			hold_len_q <= 20'h00000;
		else if (start)
			hold_len_q <= 20'h00000;
		else if (core_hold_q)
			hold_len_q <= hold_len_q + 20'h00001;
	end

	property p_page_read_len;
		@(posedge sys_clk) disable iff (rst)
		$fell(core_hold_q) && (cur_op_q == FSQ_OP_READ_PAGE || cur_op_q == FSQ_OP_CHECK_PAGE)
			|-> hold_len_q == 20'(`FSQ_T_READ_PAGE_CYC);
	endproperty
	a_page_read_len: assert property (p_page_read_len) else $error("page read length wrong");

	property p_byte_times;
		@(posedge sys_clk) disable iff (rst)
		$fell(core_hold_q) |->
			(cur_op_q == FSQ_OP_READ_BYTE -> hold_len_q == 20'(`FSQ_T_READ_BYTE_CYC))
			and (cur_op_q == FSQ_OP_PROG_BYTE -> hold_len_q == 20'(CYC_PROG_BYTE))
			and (cur_op_q == FSQ_OP_PROG_PAGE && !load_mode_q
				-> hold_len_q == 20'(CYC_PROG_PAGE));
	endproperty
	a_byte_times: assert property (p_byte_times) else $error("program or byte read length wrong");

	property p_erase_len;
		@(posedge sys_clk) disable iff (rst)
		$fell(core_hold_q) && (cur_op_q == FSQ_OP_ERASE_PAGE || cur_op_q == FSQ_OP_ERASE_ALL)
			|-> hold_len_q == 20'(CYC_ERASE);
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

	property p_load_page_len;
		@(posedge sys_clk) disable iff (rst)
		$fell(core_hold_q) && cur_op_q == FSQ_OP_PROG_PAGE && load_mode_q
			|-> hold_len_q == 20'(CYC_LOAD_PAGE);
	endproperty
	a_load_page_len: assert property (p_load_page_len) else $error("load page length wrong");

	property p_start_now;
		@(posedge sys_clk) disable iff (rst)
		cmd_wr && !core_hold_q && fsq_decode(cmd_wdata, load_mode_q) != FSQ_OP_NONE
			|=> core_hold_q && arr_q.start && arr_q.prog_array == $past(load_mode_q);
	endproperty
	a_start_now: assert property (p_start_now) else $error("operation did not start");

	property p_hold_until_done;
		@(posedge sys_clk) disable iff (rst)
		$fell(core_hold_q) |-> done_q ##1 !done_q;
	endproperty
	a_hold_until_done: assert property (p_hold_until_done) else $error("stall ended early");

	property p_check_result;
		@(posedge sys_clk) disable iff (rst)
		done_w && cur_op_q == FSQ_OP_CHECK_PAGE
			|=> (cmd_rdata_q == 8'h00) == ($past(arr_rd_data) == $past(data_regs));
	endproperty
	a_check_result: assert property (p_check_result) else $error("check readback wrong");

	property p_mode_switch;
		@(posedge sys_clk) disable iff (rst)
		cmd_wr && !core_hold_q && cmd_wdata == `FSQ_CMD_ENTER_LOAD |=> load_mode_q;
	endproperty
	a_mode_switch: assert property (p_mode_switch) else $error("load mode not entered");

	property p_erase_all;
		@(posedge sys_clk) disable iff (rst)
		cmd_wr && !core_hold_q && cmd_wdata == `FSQ_CMD_ERASE_ALL
			|=> arr_q.start && arr_q.op == FSQ_OP_ERASE_ALL;
	endproperty
	a_erase_all: assert property (p_erase_all) else $error("array erase not issued");

endmodule

// ===== test/fsq_array_model.sv
// behavioural flash array standing on the far side of the sequencer
module fsq_array_model
#(
	parameter logic [31:0] INIT_WORD = 32'hc3a5_0f69
)
(
	input  wire logic                  sys_clk,     // machine clock
	input  wire fsq_pkg::fsq_arr_req_t arr_q,       // request from the sequencer
	input  wire logic                  core_hold_q, // busy window
	input  wire logic [31:0]           data_regs,   // words to program
	output logic [31:0]                arr_rd_data  // word back to the sequencer
);
	import fsq_pkg::*;

	logic [31:0] mem_q [2];

	// ======================================================
	// both arrays start from a known word
	initial
	begin
		mem_q[0] = INIT_WORD;
		mem_q[1] = INIT_WORD;
	end

	// erase fills with ones; programming can only clear bits
	always @(posedge sys_clk)
	begin
		if (arr_q.start)
		begin
			case (arr_q.op)
				FSQ_OP_ERASE_PAGE, FSQ_OP_ERASE_ALL: mem_q[arr_q.prog_array] <= '1;
				FSQ_OP_PROG_PAGE: mem_q[arr_q.prog_array] <= mem_q[arr_q.prog_array] & data_regs;
				FSQ_OP_PROG_BYTE: mem_q[arr_q.prog_array] <= mem_q[arr_q.prog_array]
					& {24'hff_ffff, data_regs[7:0]};
				default: ;
			endcase
		end
	end

	// outside the busy window the bus shows garbage, not the last word
	assign arr_rd_data = core_hold_q ? mem_q[arr_q.prog_array] : ~mem_q[arr_q.prog_array];
endmodule

// ===== test/tb.sv
// self-checking bench for the flash command timing sequencer
`include "fsq_map.svh"
`define FSQ_TB_CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
	$display("mismatch %s exp %0h got %0h", nm, ex, got); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import fsq_pkg::*;

	// ======================================================
	// short timings keep the run small; expectations follow them
	localparam logic [14:0] T_PP  = 15'h0003;
	localparam logic [14:0] T_PB  = 15'h0002;
	localparam logic [14:0] T_ER  = 15'h0004;
	localparam logic [14:0] T_LP  = 15'h0005;
	localparam int          US    = `FSQ_CLK_MHZ;
	localparam logic [31:0] INIT  = 32'hc3a5_0f69;
	localparam int          LIMIT = 4000;

	logic         sys_clk;
	logic         rst;
	logic         cmd_wr;
	logic [7:0]   cmd_wdata;
	logic [31:0]  data_regs;
	logic [31:0]  arr_rd_data;
	logic [7:0]   cmd_rdata_q;
	logic         core_hold_q;
	logic         load_mode_q;
	fsq_arr_req_t arr_q;
	logic [31:0]  rd_data_q;
	logic         rd_load_q;
	logic         done_q;
	logic         lm;
	int           err_total;
	int           cmp_count;
	int           cyc;

	fsq_sequencer #(.T_PROG_PAGE_US(T_PP), .T_PROG_BYTE_US(T_PB), .T_ERASE_US(T_ER),
		.T_LOAD_PAGE_US(T_LP)) dut (.sys_clk(sys_clk), .rst(rst), .cmd_wr(cmd_wr),
		.cmd_wdata(cmd_wdata), .data_regs(data_regs), .arr_rd_data(arr_rd_data),
		.cmd_rdata_q(cmd_rdata_q), .core_hold_q(core_hold_q), .load_mode_q(load_mode_q),
		.arr_q(arr_q), .rd_data_q(rd_data_q), .rd_load_q(rd_load_q), .done_q(done_q));

	fsq_array_model #(.INIT_WORD(INIT)) u_array (.sys_clk(sys_clk), .arr_q(arr_q),
		.core_hold_q(core_hold_q), .data_regs(data_regs), .arr_rd_data(arr_rd_data));

	// ======================================================
	// clock and hang guard
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc >= LIMIT)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one command: write it, count the stall, judge the ending
	task automatic do_cmd(input logic [7:0] code, input int n_exp, input fsq_op_t op,
		input logic [7:0] rb, input logic ld, input logic poke);
		int n;
		n = 0;
		cmd_wdata = code;
		cmd_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_wr = 1'b0;
		`FSQ_TB_CHK("hold", n_exp > 0, core_hold_q)
		if (n_exp > 0)
		begin
			`FSQ_TB_CHK("start", 1'b1, arr_q.start)
			`FSQ_TB_CHK("op", op, arr_q.op)
			`FSQ_TB_CHK("array", lm, arr_q.prog_array)
		end
		// a write poked in mid-stall must not restart anything
		while (core_hold_q === 1'b1 && n < 20000)
		begin
			n++;
			if (poke)
				cmd_wr = (n == 3);
			@(posedge sys_clk);
			#1;
		end
		`FSQ_TB_CHK("cycles", n_exp, n)
		`FSQ_TB_CHK("done", n_exp > 0, done_q)
		`FSQ_TB_CHK("rd_load", ld, rd_load_q)
		`FSQ_TB_CHK("readback", rb, cmd_rdata_q)
	endtask

	// ======================================================
	// scenarios
	task automatic t_reset();
		`FSQ_TB_CHK("rst hold", 1'b0, core_hold_q)
		`FSQ_TB_CHK("rst done", 1'b0, done_q)
		`FSQ_TB_CHK("rst op", FSQ_OP_NONE, arr_q.op)
		`FSQ_TB_CHK("rst mode", 1'b0, load_mode_q)
	endtask

	task automatic t_reads();
		do_cmd(`FSQ_CMD_READ_PAGE, `FSQ_T_READ_PAGE_CYC, FSQ_OP_READ_PAGE, 8'h01, 1'b1, 1'b0);
		`FSQ_TB_CHK("rd_data", INIT, rd_data_q)
		do_cmd(`FSQ_CMD_READ_BYTE, `FSQ_T_READ_BYTE_CYC, FSQ_OP_READ_BYTE, 8'h81, 1'b1, 1'b0);
	endtask

	// erase, program, then check a match and a miss back to back
	task automatic t_data_prog();
		data_regs = 32'h1234_f3ab;
		do_cmd(`FSQ_CMD_ERASE_PAGE, T_ER * US, FSQ_OP_ERASE_PAGE, 8'h05, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_PROG_PAGE, T_PP * US, FSQ_OP_PROG_PAGE, 8'h02, 1'b0, 1'b1);
		do_cmd(`FSQ_CMD_CHECK_PAGE, 22, FSQ_OP_CHECK_PAGE, `FSQ_CHECK_PASS, 1'b0, 1'b0);
		data_regs = 32'h1234_f3aa;
		do_cmd(`FSQ_CMD_CHECK_PAGE, 22, FSQ_OP_CHECK_PAGE, `FSQ_CHECK_FAIL, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_PROG_BYTE, T_PB * US, FSQ_OP_PROG_BYTE, 8'h82, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_ERASE_ALL, T_ER * US, FSQ_OP_ERASE_ALL, 8'h06, 1'b0, 1'b0);
		do_cmd(8'h03, 0, FSQ_OP_NONE, 8'h03, 1'b0, 1'b0);
	endtask

	task automatic t_load_mode();
		do_cmd(`FSQ_CMD_ENTER_LOAD, 0, FSQ_OP_NONE, 8'hf0, 1'b0, 1'b0);
		`FSQ_TB_CHK("mode on", 1'b1, load_mode_q)
		lm = 1'b1;
		do_cmd(`FSQ_CMD_PROG_PAGE, T_LP * US, FSQ_OP_PROG_PAGE, 8'h02, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_PROG_BYTE, T_PB * US, FSQ_OP_PROG_BYTE, 8'h82, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_ERASE_PAGE, T_ER * US, FSQ_OP_ERASE_PAGE, 8'h05, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_ERASE_ALL, T_ER * US, FSQ_OP_ERASE_ALL, 8'h06, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_READ_PAGE, 0, FSQ_OP_NONE, 8'h01, 1'b0, 1'b0);
		do_cmd(`FSQ_CMD_LEAVE_LOAD, 0, FSQ_OP_NONE, 8'h0f, 1'b0, 1'b0);
		`FSQ_TB_CHK("mode off", 1'b0, load_mode_q)
		lm = 1'b0;
		do_cmd(`FSQ_CMD_READ_PAGE, 22, FSQ_OP_READ_PAGE, 8'h01, 1'b1, 1'b0);
	endtask

	// ======================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		cmd_wr = 1'b0;
		cmd_wdata = 8'h00;
		data_regs = 32'h0000_0000;
		lm = 1'b0;
		err_total = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_reads();
		t_data_prog();
		t_load_mode();
		tally_and_finish();
	end
endmodule
